/* File: verilog/ssl_supervisor.sv */
// Supply supervisor: reset stretch, CE gating, flags, watchdog, bus slave
`timescale 1ns/100ps
`include "ssl_consts.svh"

// How it works
// - CE out copies CE in while supply good
// - CE out forced high below threshold
// - Early fail flag follows sense comparator
// - Deep backup forces early fail flag low
// - Backup flag high only in backup
// - Low supply flag follows threshold directly
// - Reset held while supply below threshold
// - Reset stretched 200 ms after recovery
// - No kick for 1.6 s gives reset
// - Reset repeats each period without kicks
// - Expired flag low on timeout
// - Expired flag cleared by next kick edge
// - Floating kick input disables watchdog
// - High reset is complement of low reset
// - Watchdog restarts long after every reset
// - Short 100 ms period when source low and select floats, after first kick
module ssl_supervisor #(
    parameter int TICK_CYCLES    = `SSL_TICK_CYCLES,
    parameter int RESET_TICKS    = `SSL_RESET_TICKS,
    parameter int WD_LONG_TICKS  = `SSL_WD_LONG_TICKS,
    parameter int WD_SHORT_TICKS = `SSL_WD_SHORT_TICKS
) (
    input  wire logic               CORE_CLK_I,
    input  wire logic               RST_B_I,
    input  wire ssl_pkg::ssl_sense_t SENSE_I,
    input  wire logic [3:0]         AVS_ADDRESS_I,
    input  wire logic               AVS_READ_I,
    input  wire logic               AVS_WRITE_I,
    input  wire logic [31:0]        AVS_WRITEDATA_I,
    input  wire logic [3:0]         AVS_BYTEENABLE_I,
    output logic [31:0]             AVS_READDATA_O,
    output logic                    AVS_WAITREQUEST_O,
    output logic                    RESET_N_O,
    output logic                    RESET_O,
    output logic                    GATED_CHIP_ENABLE_N_O,
    output logic                    SUPPLY_LOW_FLAG_N_O,
    output logic                    EARLY_FAIL_FLAG_N_O,
    output logic                    BACKUP_ACTIVE_O,
    output logic                    WATCHDOG_EXPIRED_N_O,
    output logic                    IRQ_O
);

    localparam int TW = `SSL_TICK_W;
    localparam int RW = `SSL_RST_W;
    localparam int WW = `SSL_WD_W;

    if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << TW) ||
        RESET_TICKS < 1 || RESET_TICKS > (1 << RW) ||
        WD_SHORT_TICKS < 1 || WD_LONG_TICKS < WD_SHORT_TICKS ||
        WD_LONG_TICKS > (1 << WW)) begin : g_bad_param
        $error("ssl_supervisor: timing parameter out of range");
    end

    localparam logic [TW-1:0] TICK_LAST  = TW'(TICK_CYCLES - 1);
    localparam logic [RW-1:0] RST_LAST   = RW'(RESET_TICKS - 1);
    localparam logic [WW-1:0] LONG_LAST  = WW'(WD_LONG_TICKS - 1);
    localparam logic [WW-1:0] SHORT_LAST = WW'(WD_SHORT_TICKS - 1);

    ssl_pkg::ssl_state_t s_reg;
    ssl_pkg::ssl_state_t s_next;

    logic                backup;
    logic                kick_edge;
    logic                wd_off;
    logic                short_sel;
    logic [WW-1:0]       wd_last;
    logic                bus_req;
    logic                bus_hit;
    logic [`SSL_EV_W-1:0] ev;
    logic [`SSL_EV_W-1:0] clr;

    function automatic logic [31:0] read_reg(
        input logic [3:0]          addr,
        input ssl_pkg::ssl_state_t st
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (addr)
            `SSL_OFS_STATUS: begin
                d[WW+15:16] = st.wd_cnt;
                d[6:0] = {st.short_ok, st.rst_n, st.wdo_n, st.batt,
                          st.pfo_n, st.low_n, st.ce_n};
            end
            `SSL_OFS_IRQ_STAT: d[`SSL_EV_W-1:0] = st.irq_stat;
            `SSL_OFS_IRQ_MASK: d[`SSL_EV_W-1:0] = st.irq_mask;
            `SSL_OFS_CTRL:     d[`SSL_CTRL_WD_DIS] = st.wd_dis;
            default:           d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    always_comb begin
        s_next = s_reg;
        // Fixed rate timing tick
        s_next.tick = 1'b0;
        if (s_reg.tick_cnt == TICK_LAST) begin
            s_next.tick_cnt = '0;
            s_next.tick     = 1'b1;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + TW'(1);
        end

        backup    = !SENSE_I.supply_ok && !SENSE_I.above_batt;
        kick_edge = SENSE_I.watchdog_kick != s_reg.kick_prev;
        s_next.kick_prev = SENSE_I.watchdog_kick;
        wd_off    = SENSE_I.kick_float || s_reg.wd_dis || backup;
        short_sel = SENSE_I.timing_source_low &&
                    SENSE_I.timing_select_float;
        // Short period only after first kick past reset
        wd_last   = (s_reg.short_ok && short_sel) ? SHORT_LAST : LONG_LAST;

        if (!SENSE_I.supply_ok) begin
            // Hold reset, clear watchdog, release expired flag
            s_next.rst_n    = 1'b0;
            s_next.rst_cnt  = '0;
            s_next.wd_cnt   = '0;
            s_next.short_ok = 1'b0;
            s_next.wdo_n    = 1'b1;
        end else begin
            if (kick_edge && !wd_off) begin
                s_next.wdo_n = 1'b1;
            end
            if (!s_reg.rst_n) begin
                s_next.wd_cnt   = '0;
                s_next.short_ok = 1'b0;
                if (s_reg.tick) begin
                    if (s_reg.rst_cnt == RST_LAST) begin
                        s_next.rst_n   = 1'b1;
                        s_next.rst_cnt = '0;
                    end else begin
                        s_next.rst_cnt = s_reg.rst_cnt + RW'(1);
                    end
                end
            end else if (wd_off) begin
                s_next.wd_cnt = '0;
            end else if (kick_edge) begin
                s_next.wd_cnt   = '0;
                s_next.short_ok = 1'b1;
            end else if (s_reg.tick) begin
                if (s_reg.wd_cnt == wd_last) begin
                    // Timeout: flag and a fresh reset pulse
                    s_next.wdo_n   = 1'b0;
                    s_next.rst_n   = 1'b0;
                    s_next.rst_cnt = '0;
                    s_next.wd_cnt  = '0;
                end else begin
                    s_next.wd_cnt = s_reg.wd_cnt + WW'(1);
                end
            end
        end
        s_next.rst_hi = !s_next.rst_n;

        s_next.ce_n  = SENSE_I.supply_ok ?
                       SENSE_I.chip_enable_n : 1'b1;
        s_next.low_n = SENSE_I.supply_ok;
        s_next.pfo_n = (backup && !SENSE_I.batt_margin_ok) ?
                       1'b0 : SENSE_I.early_fail_sense;
        s_next.batt  = backup;

        // Sticky events, set wins over clear
        ev[`SSL_EV_SUPPLY_LOW] = s_reg.low_n && !s_next.low_n;
        ev[`SSL_EV_EARLY_FAIL] = s_reg.pfo_n && !s_next.pfo_n;
        ev[`SSL_EV_WD_EXPIRED] = s_reg.wdo_n && !s_next.wdo_n;
        ev[`SSL_EV_BACKUP]     = !s_reg.batt && s_next.batt;
        ev[`SSL_EV_RESET_DONE] = !s_reg.rst_n && s_next.rst_n;

        // Bus: one wait cycle, then a single ready cycle
        bus_req = AVS_READ_I || AVS_WRITE_I;
        bus_hit = AVS_WRITE_I && !s_reg.wait_r && AVS_BYTEENABLE_I[0];
        s_next.wait_r = !(bus_req && s_reg.wait_r);
        if (bus_req && s_reg.wait_r) begin
            s_next.rdata = AVS_READ_I ?
                           read_reg(AVS_ADDRESS_I, s_reg) : 32'h0000_0000;
        end
        clr = '0;
        if (bus_hit) begin
            unique case (AVS_ADDRESS_I)
                `SSL_OFS_IRQ_STAT: clr = AVS_WRITEDATA_I[`SSL_EV_W-1:0];
                `SSL_OFS_IRQ_MASK:
                    s_next.irq_mask = AVS_WRITEDATA_I[`SSL_EV_W-1:0];
                `SSL_OFS_CTRL:
                    s_next.wd_dis = AVS_WRITEDATA_I[`SSL_CTRL_WD_DIS];
                default: clr = '0;
            endcase
        end
        s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
        s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s_reg          <= '0;
            s_reg.rst_hi   <= 1'b1;
            s_reg.wdo_n    <= 1'b1;
            s_reg.ce_n     <= 1'b1;
            s_reg.irq_mask <= `SSL_IRQ_MASK_RST;
            s_reg.wd_dis   <= `SSL_CTRL_RST;
            s_reg.wait_r   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign AVS_READDATA_O        = s_reg.rdata;
    assign AVS_WAITREQUEST_O     = s_reg.wait_r;
    assign RESET_N_O             = s_reg.rst_n;
    assign RESET_O               = s_reg.rst_hi;
    assign GATED_CHIP_ENABLE_N_O = s_reg.ce_n;
    assign SUPPLY_LOW_FLAG_N_O   = s_reg.low_n;
    assign EARLY_FAIL_FLAG_N_O   = s_reg.pfo_n;
    assign BACKUP_ACTIVE_O       = s_reg.batt;
    assign WATCHDOG_EXPIRED_N_O  = s_reg.wdo_n;
    assign IRQ_O                 = s_reg.irq;

    // Checks
    default clocking cb @(posedge CORE_CLK_I); endclocking

    // Stretch cycle count; checks start one edge past reset release
    int   hold_cyc;
    logic chk_live_reg;
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            hold_cyc     <= 0;
            chk_live_reg <= 1'b0;
        end else begin
            chk_live_reg <= 1'b1;
            hold_cyc <= (RESET_N_O || !SENSE_I.supply_ok) ? 0 : hold_cyc + 1;
        end
    end

    default disable iff (!RST_B_I || !chk_live_reg);

    property p_ce_copy;
        SENSE_I.supply_ok |=> GATED_CHIP_ENABLE_N_O ==
                              $past(SENSE_I.chip_enable_n);
    endproperty
    a_ce_copy: assert property (p_ce_copy)
        else $error("gated CE does not copy CE in");

    property p_ce_block;
        !SENSE_I.supply_ok |=> GATED_CHIP_ENABLE_N_O;
    endproperty
    a_ce_block: assert property (p_ce_block)
        else $error("gated CE not forced high");

    property p_pfo_follow;
        (SENSE_I.supply_ok || SENSE_I.above_batt || SENSE_I.batt_margin_ok)
        |=> EARLY_FAIL_FLAG_N_O == $past(SENSE_I.early_fail_sense);
    endproperty
    a_pfo_follow: assert property (p_pfo_follow)
        else $error("early fail flag does not follow sense");

    property p_pfo_forced;
        (backup && !SENSE_I.batt_margin_ok) |=> !EARLY_FAIL_FLAG_N_O;
    endproperty
    a_pfo_forced: assert property (p_pfo_forced)
        else $error("early fail flag not forced low");

    property p_batt_flag;
        ##1 BACKUP_ACTIVE_O == $past(backup);
    endproperty
    a_batt_flag: assert property (p_batt_flag)
        else $error("backup flag wrong");

    property p_low_flag;
        ##1 SUPPLY_LOW_FLAG_N_O == $past(SENSE_I.supply_ok);
    endproperty
    a_low_flag: assert property (p_low_flag)
        else $error("supply low flag wrong");

    property p_reset_hold;
        !SENSE_I.supply_ok |=> !RESET_N_O;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("reset released with supply low");

    property p_stretch;
        $rose(RESET_N_O) |-> $past(hold_cyc) >=
            (RESET_TICKS - 1) * TICK_CYCLES &&
            $past(hold_cyc) <= RESET_TICKS * TICK_CYCLES + 1;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("reset stretch length wrong");

    property p_wd_reset;
        $fell(WATCHDOG_EXPIRED_N_O) |-> $fell(RESET_N_O);
    endproperty
    a_wd_reset: assert property (p_wd_reset)
        else $error("watchdog timeout without reset pulse");

    property p_wdo_sticky;
        (SENSE_I.supply_ok && !WATCHDOG_EXPIRED_N_O &&
         !$changed(SENSE_I.watchdog_kick)) |=> !WATCHDOG_EXPIRED_N_O;
    endproperty
    a_wdo_sticky: assert property (p_wdo_sticky)
        else $error("expired flag left without a kick");

    property p_float_off;
        (SENSE_I.kick_float && RESET_N_O) |=> !$fell(RESET_N_O) ||
                                             !$past(SENSE_I.supply_ok);
    endproperty
    a_float_off: assert property (p_float_off)
        else $error("watchdog active while kick floats");

    property p_complement;
        RESET_O == !RESET_N_O;
    endproperty
    a_complement: assert property (p_complement)
        else $error("reset outputs not complementary");

    property p_restart;
        $rose(RESET_N_O) |-> s_reg.wd_cnt == '0 && !s_reg.short_ok;
    endproperty
    a_restart: assert property (p_restart)
        else $error("watchdog not restarted after reset");

    property p_backup_safe;
        backup |=> WATCHDOG_EXPIRED_N_O && GATED_CHIP_ENABLE_N_O &&
                   !RESET_N_O;
    endproperty
    a_backup_safe: assert property (p_backup_safe)
        else $error("backup outputs not safe");

    c_wd_timeout: cover property ($fell(WATCHDOG_EXPIRED_N_O));
    c_brownout:   cover property ($fell(SENSE_I.supply_ok) ##[1:20]
                                  SENSE_I.supply_ok);
    c_backup:     cover property ($rose(BACKUP_ACTIVE_O));
    c_irq:        cover property ($rose(IRQ_O));

endmodule

/* File: verilog/ssl_consts.svh */
// Offsets, field positions, reset values and timing counts of the supervisor
`ifndef SSL_CONSTS_SVH
`define SSL_CONSTS_SVH

// Timing
`define SSL_CLK_PERIOD_NS   10
`define SSL_TICK_PERIOD_NS  1000000
`define SSL_TICK_CYCLES     (`SSL_TICK_PERIOD_NS / `SSL_CLK_PERIOD_NS)
`define SSL_TICK_MS         1
`define SSL_RESET_MS        200
`define SSL_WD_LONG_MS      1600
`define SSL_WD_SHORT_MS     100
`define SSL_RESET_TICKS     (`SSL_RESET_MS / `SSL_TICK_MS)
`define SSL_WD_LONG_TICKS   (`SSL_WD_LONG_MS / `SSL_TICK_MS)
`define SSL_WD_SHORT_TICKS  (`SSL_WD_SHORT_MS / `SSL_TICK_MS)

// Counter widths
`define SSL_TICK_W          17
`define SSL_RST_W           8
`define SSL_WD_W            11

// Register byte offsets
`define SSL_ADDR_W          4
`define SSL_OFS_STATUS      4'h0
`define SSL_OFS_IRQ_STAT    4'h4
`define SSL_OFS_IRQ_MASK    4'h8
`define SSL_OFS_CTRL        4'hC

// Event bits in IRQ_STAT / IRQ_MASK
`define SSL_EV_W            5
`define SSL_EV_SUPPLY_LOW   0
`define SSL_EV_EARLY_FAIL   1
`define SSL_EV_WD_EXPIRED   2
`define SSL_EV_BACKUP       3
`define SSL_EV_RESET_DONE   4

// CTRL fields and reset values
`define SSL_CTRL_WD_DIS     0
`define SSL_IRQ_MASK_RST    5'h00
`define SSL_CTRL_RST        1'b0

`endif

/* File: verilog/ssl_pkg.sv */
// Types of the supply supervisor logic
package ssl_pkg;

    // Digitised comparator results and host-side pins
    typedef struct packed {
        logic supply_ok;          // Supply at or above reset threshold
        logic above_batt;         // Supply above battery voltage
        logic batt_margin_ok;     // Supply at most 1.2 V below battery or up
        logic early_fail_sense;   // 1: early fail input above reference
        logic chip_enable_n;      // Chip enable from host, active low
        logic watchdog_kick;
        logic kick_float;         // Kick input detected floating
        logic timing_source_low;  // Timing source pin tied low
        logic timing_select_float;
    } ssl_sense_t;

    typedef struct packed {
        logic [16:0] tick_cnt;
        logic        tick;
        logic [7:0]  rst_cnt;
        logic        rst_n;
        logic        rst_hi;
        logic [10:0] wd_cnt;
        logic        short_ok;
        logic        kick_prev;
        logic        wdo_n;
        logic        ce_n;
        logic        pfo_n;
        logic        low_n;
        logic        batt;
        logic [4:0]  irq_stat;
        logic [4:0]  irq_mask;
        logic        irq;
        logic        wd_dis;
        logic        wait_r;
        logic [31:0] rdata;
    } ssl_state_t;

endpackage

/* File: verification/ssl_host_model.sv */
// Host model that services the watchdog input
`timescale 1ns/100ps
module ssl_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        en_i,
    input  wire logic [15:0] period_i,
    output logic             kick_o
);
    logic [15:0] cnt_reg;

    // Toggle once a period while enabled, hold level when stalled
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 16'h0000;
            kick_o  <= 1'b0;
        end else if (en_i && cnt_reg >= period_i) begin
            cnt_reg <= 16'h0000;
            kick_o  <= ~kick_o;
        end else if (en_i) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench of the supply supervisor
`timescale 1ns/100ps
module tb_top;
    localparam int TC = 10;
    localparam int RT = 4;
    localparam int WL = 16;
    localparam int WS = 2;
    localparam logic [3:0]  TA [3] = '{4'h8, 4'hc, 4'h2};
    localparam logic [3:0]  TB [3] = '{4'hf, 4'h0, 4'hf};
    localparam logic [31:0] TD [3] = '{32'h1f, 32'h1, 32'hff};
    localparam logic [31:0] TE [3] = '{32'h1f, 32'h0, 32'h0};

    logic                clk, rst_b, rd, wr, host_en, host_kick;
    logic [3:0]          adr, be;
    logic [31:0]         wd, q;
    ssl_pkg::ssl_sense_t sense, sense_dut;
    logic [31:0] AVS_READDATA_O;
    logic AVS_WAITREQUEST_O, RESET_N_O, RESET_O, GATED_CHIP_ENABLE_N_O;
    logic SUPPLY_LOW_FLAG_N_O, EARLY_FAIL_FLAG_N_O, BACKUP_ACTIVE_O;
    logic WATCHDOG_EXPIRED_N_O, IRQ_O;
    int   num_errors, n_compared, n;

    always #5 clk = ~clk;

    always_comb begin
        sense_dut = sense;
        if (host_en)
            sense_dut.watchdog_kick = host_kick;
    end

    ssl_supervisor #(.TICK_CYCLES(TC), .RESET_TICKS(RT),
        .WD_LONG_TICKS(WL), .WD_SHORT_TICKS(WS)) i_ssl_supervisor (
        .CORE_CLK_I(clk), .RST_B_I(rst_b), .SENSE_I(sense_dut),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(AVS_READDATA_O),
        .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
        .RESET_N_O(RESET_N_O), .RESET_O(RESET_O),
        .GATED_CHIP_ENABLE_N_O(GATED_CHIP_ENABLE_N_O),
        .SUPPLY_LOW_FLAG_N_O(SUPPLY_LOW_FLAG_N_O),
        .EARLY_FAIL_FLAG_N_O(EARLY_FAIL_FLAG_N_O),
        .BACKUP_ACTIVE_O(BACKUP_ACTIVE_O),
        .WATCHDOG_EXPIRED_N_O(WATCHDOG_EXPIRED_N_O), .IRQ_O(IRQ_O));

    ssl_host_model i_ssl_host_model (.clk_i(clk), .rst_b_i(rst_b),
        .en_i(host_en), .period_i(16'(WL * TC / 2)), .kick_o(host_kick));

    task automatic results();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    // Behavioural model of the flags for the current sense levels
    task automatic chk_flags();
        logic       bk;
        logic [3:0] e;
        bk = !sense.supply_ok && !sense.above_batt;
        e[0] = sense.supply_ok ? sense.chip_enable_n : 1'b1;
        e[1] = sense.supply_ok;
        e[2] = (bk && !sense.batt_margin_ok) ? 1'b0 : sense.early_fail_sense;
        e[3] = bk;
        chk({BACKUP_ACTIVE_O, EARLY_FAIL_FLAG_N_O, SUPPLY_LOW_FLAG_N_O,
             GATED_CHIP_ENABLE_N_O}, e);
        if (!sense.supply_ok)
            chk({RESET_N_O, RESET_O, WATCHDOG_EXPIRED_N_O},
                3'b011);
    endtask

    task automatic wait_lvl(input int w, input logic v, input int maxc,
                            output int cnt);
        cnt = 0;
        while ((w == 0 ? RESET_N_O : WATCHDOG_EXPIRED_N_O) !== v) begin
            @(posedge clk);
            #1;
            cnt++;
            if (cnt > maxc) begin
                num_errors++;
                $display("mismatch t=%0t got=%h exp=%h", $time, !v, v);
                results();
            end
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk);
        rd  <= !w;
        wr  <= w;
        adr <= a;
        wd  <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (k > 20) begin
                num_errors++;
                $display("mismatch t=%0t got=%h exp=%h", $time, 1, 0);
                results();
            end
        end while (AVS_WAITREQUEST_O !== 1'b0);
        r = AVS_READDATA_O;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic watch(input int cycles);
        int bad;
        bad = 0;
        repeat (cycles) begin
            @(posedge clk);
            #1;
            if (WATCHDOG_EXPIRED_N_O !== 1'b1 || RESET_N_O !== 1'b1)
                bad++;
        end
        chk_rng(bad, 0, 0);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        results();
    end

    initial begin
        clk = 0; rst_b = 0; rd = 0; wr = 0; adr = 0; wd = 0;
        be = 4'hf; host_en = 0; num_errors = 0; n_compared = 0;
        sense = 9'h1f1;
        void'($urandom(32'h4ce5));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wait_lvl(0, 1'b1, (RT + 2) * TC, n);
        chk_rng(n, (RT - 1) * TC, (RT + 1) * TC + 3);
        for (int i = 0; i < 3; i++) begin
            bus(0, TA[i], 32'h0, q);
            chk(q, 32'h0);
            be <= TB[i];
            bus(1, TA[i], TD[i], q);
            be <= 4'hf;
            bus(0, TA[i], 32'h0, q);
            chk(q, TE[i]);
        end
        // Supply loss event, unmasked, raises the interrupt and a status write clears it
        bus(1, 4'h4, 32'h1f, q);
        bus(1, 4'h8, 32'h1, q);
        chk({31'h0, IRQ_O}, 32'h0);
        @(posedge clk);
        sense.supply_ok <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_flags();
        chk({31'h0, IRQ_O}, 32'h1);
        bus(1, 4'h4, 32'h1, q);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, IRQ_O}, 32'h0);
        @(posedge clk);
        sense.supply_ok <= 1'b1;
        wait_lvl(0, 1'b1, (RT + 3) * TC, n);
        chk_rng(n, (RT - 1) * TC, (RT + 1) * TC + 3);
        bus(0, 4'h4, 32'h0, q);
        chk({31'h0, q[4]}, 32'h1);
        repeat (30) begin
            @(posedge clk);
            sense[8:4] <= 5'($urandom);
            repeat (2) @(posedge clk);
            #1;
            chk_flags();
        end
        @(posedge clk);
        sense[8:4] <= 5'h0f;
        repeat (2) @(posedge clk);
        sense[8:4] <= 5'h1f;
        wait_lvl(0, 1'b1, (RT + 3) * TC, n);
        chk_rng(n, (RT - 1) * TC, (RT + 1) * TC + 3);
        // Watchdog runs out without kicks, long period
        wait_lvl(1, 1'b0, (WL + 3) * TC, n);
        chk_rng(n, WL * TC, (WL + 2) * TC + 3);
        chk({RESET_N_O, RESET_O}, 2'b01);
        wait_lvl(0, 1'b1, (RT + 2) * TC, n);
        chk_rng(n, (RT - 1) * TC, (RT + 1) * TC + 3);
        wait_lvl(0, 1'b0, (WL + 3) * TC, n);
        chk_rng(n, WL * TC, (WL + 2) * TC + 3);
        chk({31'h0, WATCHDOG_EXPIRED_N_O}, 32'h0);
        wait_lvl(0, 1'b1, (RT + 2) * TC, n);
        @(posedge clk);
        sense.watchdog_kick <= 1'b1;
        sense.timing_source_low <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, WATCHDOG_EXPIRED_N_O}, 32'h1);
        wait_lvl(1, 1'b0, (WL + 3) * TC, n);
        chk_rng(n, (WS - 1) * TC, (WS + 2) * TC + 3);
        wait_lvl(0, 1'b1, (RT + 2) * TC, n);
        wait_lvl(0, 1'b0, (WL + 3) * TC, n);
        chk_rng(n, WL * TC, (WL + 2) * TC + 3);
        wait_lvl(0, 1'b1, (RT + 2) * TC, n);
        @(posedge clk);
        sense.timing_source_low <= 1'b0;
        host_en <= 1'b1;
        repeat (WL * TC / 2 + 20) @(posedge clk);
        watch(3 * WL * TC);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            host_en <= 1'b0;
            sense.kick_float <= (m == 0);
            if (m == 1)
                bus(1, 4'hc, 32'h1, q);
            watch((WL + 4) * TC);
            @(posedge clk);
            sense.kick_float <= 1'b0;
        end
        results();
    end
endmodule
